// [dmba_core_model.sv]
// core-side model issuing accesses
`timescale 1ns/1ps
module dmba_core_model
	import dmba_pkg::*;
(
	// clock
	input wire logic i_clk,
	// status from block
	input wire logic i_busy,
	input wire logic i_rd_valid,
	input wire logic [7:0] i_rd_data,
	input wire logic i_wr_done,
	// instruction to block
	output logic o_start,
	output dmba_op_t o_op,
	output logic o_access_bit,
	output logic [7:0] o_offset,
	output logic [11:0] o_src_addr,
	output logic [11:0] o_dst_addr,
	output logic [7:0] o_literal,
	output logic o_write,
	output logic [7:0] o_wr_data
);
	initial begin
		o_op = DMBA_OP_NONE;
		{o_start, o_access_bit, o_offset, o_src_addr, o_dst_addr} = '0;
		{o_literal, o_write, o_wr_data} = '0;
	end
	task issue(input dmba_op_t op, input logic a, input logic [7:0] off, input logic [11:0] s, d,
		input logic wr, input logic [7:0] wd, output logic [7:0] rd, output logic dn,
		output logic ok);
		int n;
		n = 0;
		rd = 'x;
		dn = 1'b0;
		@(negedge i_clk);
		{o_access_bit, o_offset, o_src_addr, o_dst_addr, o_literal} = {a, off, s, d, off};
		o_op = op;
		o_write = wr;
		o_wr_data = wd;
		o_start = 1'b1;
		while (!i_busy && n < 9) begin
			@(negedge i_clk);
			n++;
		end
		ok = (i_busy === 1'b1);
		o_start = 1'b0;
		o_offset = ~off;
		o_wr_data = ~wd;
		while (i_busy && n < 20) begin
			@(negedge i_clk);
			if (i_rd_valid) rd = i_rd_data;
			if (i_wr_done) dn = 1'b1;
			n++;
		end
		ok = ok && (i_busy === 1'b0);
	endtask : issue
endmodule : dmba_core_model

// [dmba_mem_if.sv]
// interface between address generator and data array
`timescale 1ns/1ps
interface dmba_mem_if;
	logic [11:0] rd_addr;
	logic [11:0] wr_addr;
	logic rd_en;
	logic wr_en;
	logic [7:0] wr_data;
	logic [7:0] rd_data;
	modport ctrl (output rd_addr, wr_addr, rd_en, wr_en, wr_data, input rd_data);
	modport mem (input rd_addr, wr_addr, rd_en, wr_en, wr_data, output rd_data);
endinterface : dmba_mem_if

// [dmba_monitor.sv]
// assertion checker for bank addressing
`timescale 1ns/1ps
module dmba_monitor
	import dmba_pkg::*;
(
	// clock and reset
	input wire logic i_clk,
	input wire logic i_reset,
	// request
	input wire logic i_start,
	input wire dmba_op_t i_op,
	input wire logic i_access_bit,
	input wire logic [7:0] i_offset,
	input wire logic [11:0] i_src_addr,
	input wire logic [7:0] i_literal,
	// results
	input wire logic [11:0] o_addr,
	input wire logic o_rd_valid,
	input wire logic [7:0] o_bank_select,
	input wire logic o_busy
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_reset);
	sequence s_take;
		$rose(o_busy);
	endsequence
	sequence s_op(dmba_op_t k);
		s_take ##0 $past(i_op) == k;
	endsequence
	chk_take_cause: assert property (s_take |-> $past(i_start))
		else $error("busy without start");
	chk_valid_time: assert property (s_take ##0 ($past(i_op) == DMBA_OP_BANKED
		|| $past(i_op) == DMBA_OP_FULL) |-> ##2 o_rd_valid) else $error("read late");
	chk_busy_len: assert property (s_take |-> o_busy[*3] ##1 !o_busy)
		else $error("busy length");
	chk_one_pulse: assert property (o_rd_valid |=> !o_rd_valid)
		else $error("valid too long");
	chk_bank_upper: assert property (o_bank_select[7:4] == 4'h0)
		else $error("bank upper bits");
	chk_banked_addr: assert property (s_op(DMBA_OP_BANKED) ##0 $past(i_access_bit)
		|-> o_addr == {o_bank_select[3:0], $past(i_offset)}) else $error("banked addr");
	chk_access_addr: assert property (s_op(DMBA_OP_BANKED) ##0 !$past(i_access_bit)
		|-> o_addr == {{4{$past(i_offset[7])}}, $past(i_offset)}) else $error("access addr");
	chk_full_addr: assert property (s_op(DMBA_OP_FULL) |-> o_addr == $past(i_src_addr))
		else $error("full addr");
	chk_load_bank: assert property (s_op(DMBA_OP_LOAD_BANK)
		|-> ##4 o_bank_select == {4'h0, $past(i_literal[3:0], 5)}) else $error("bank load");
endmodule : dmba_monitor
bind dmba_top dmba_monitor i_dmba_monitor (.*);

// [dmba_pkg.sv]
// constants and types for the data memory bank addressing block
package dmba_pkg;
	// ----------------------------------------
	// sizes and map
	// ----------------------------------------
	localparam int DMBA_ADDR_W = 12;
	localparam int DMBA_DEPTH = 4096;
	localparam int DMBA_BANKS = 16;
	localparam logic [15:0] DMBA_BANK_IMPL = 16'hffff;
	localparam logic [11:0] DMBA_GPR_BASE = 12'h000;
	localparam logic [11:0] DMBA_SFR_BASE = 12'hf80;
	localparam logic [11:0] DMBA_SFR_TOP = 12'hfff;
	localparam logic [11:0] DMBA_BANK_SEL_ADDR = 12'hfe0;
	localparam logic [3:0] DMBA_BANK_RESET = 4'h0;
	localparam logic [3:0] DMBA_ACC_LOW_BANK = 4'h0;
	localparam logic [3:0] DMBA_ACC_HIGH_BANK = 4'hf;
	localparam logic [1:0] DMBA_PHASE_RESET = 2'h0;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [1:0] {
		DMBA_OP_NONE,
		DMBA_OP_BANKED,
		DMBA_OP_FULL,
		DMBA_OP_LOAD_BANK
	} dmba_op_t;

	typedef enum {
		DMBA_Q1,
		DMBA_Q2,
		DMBA_Q3,
		DMBA_Q4
	} dmba_phase_t;
endpackage : dmba_pkg

// [dmba_ram.sv]
// banked data array, not touched by reset
`timescale 1ns/1ps
module dmba_ram
	import dmba_pkg::*;
(
	// clock
	input wire logic i_clk,
	// memory side
	dmba_mem_if.mem mem
);
	logic [7:0] cells [0:DMBA_DEPTH-1];
	logic [7:0] rd_q;

	always_ff @(posedge i_clk) begin
		if (mem.wr_en && DMBA_BANK_IMPL[mem.wr_addr[11:8]]) begin
			cells[mem.wr_addr] <= mem.wr_data;
		end
	end

	always_ff @(posedge i_clk) begin
		if (mem.rd_en) begin
			rd_q <= DMBA_BANK_IMPL[mem.rd_addr[11:8]] ? cells[mem.rd_addr] : 8'h00;
		end
	end

	assign mem.rd_data = rd_q;
endmodule : dmba_ram

// [dmba_top.sv]
// data memory bank address generation and access sequencing
`timescale 1ns/1ps
module dmba_top
	import dmba_pkg::*;
(
	// clock and reset
	input wire logic i_clk,
	input wire logic i_reset,
	// instruction from core
	input wire logic i_start,
	input wire dmba_op_t i_op,
	input wire logic i_access_bit,
	input wire logic [7:0] i_offset,
	input wire logic [11:0] i_src_addr,
	input wire logic [11:0] i_dst_addr,
	input wire logic [7:0] i_literal,
	input wire logic i_write,
	input wire logic [7:0] i_wr_data,
	input wire logic i_ext_set_enable,
	// results
	output logic [11:0] o_addr,
	output logic [7:0] o_rd_data,
	output logic o_rd_valid,
	output logic o_wr_done,
	output logic [7:0] o_bank_select,
	output logic o_busy
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	dmba_mem_if mif ();
	dmba_phase_t phase;
	logic [3:0] bank_select;
	logic [11:0] rd_addr;
	logic [11:0] wr_addr;
	logic [7:0] wr_data;
	logic do_read;
	logic do_write;
	logic full_move;
	logic load_bank;
	logic [7:0] lit_q;
	logic [11:0] next_addr;
	logic rd_pending;
	logic [7:0] sfr_rd;
	logic sfr_hit;
	logic [3:0] next_bank_select;

	// ----------------------------------------
	// address formation
	// ----------------------------------------
	always_comb begin
		next_addr = {DMBA_BANK_RESET, i_offset};
		if (i_op == DMBA_OP_FULL) begin
			next_addr = i_src_addr;
		end else if (i_access_bit) begin
			next_addr = {bank_select, i_offset};
		end else begin
			next_addr = {i_offset[7] ? DMBA_ACC_HIGH_BANK : DMBA_ACC_LOW_BANK, i_offset};
		end
	end

	// ----------------------------------------
	// quarter phase sequencer
	// ----------------------------------------
	// one instruction cycle per access
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			phase <= DMBA_Q1;
		end else begin
			case (phase)
				DMBA_Q1: begin
					if (i_start) begin
						phase <= DMBA_Q2;
					end
				end
				DMBA_Q2: phase <= DMBA_Q3;
				DMBA_Q3: phase <= DMBA_Q4;
				DMBA_Q4: phase <= DMBA_Q1;
				default: phase <= DMBA_Q1;
			endcase
		end
	end

	// latched instruction fields
	// non-full ops use low byte
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			rd_addr <= 12'h000;
			wr_addr <= 12'h000;
			wr_data <= 8'h00;
			do_read <= 1'b0;
			do_write <= 1'b0;
			full_move <= 1'b0;
			load_bank <= 1'b0;
			lit_q <= 8'h00;
		end else if (phase == DMBA_Q1 && i_start) begin
			rd_addr <= next_addr;
			wr_addr <= (i_op == DMBA_OP_FULL) ? i_dst_addr : next_addr;
			wr_data <= i_wr_data;
			do_read <= (i_op == DMBA_OP_BANKED) || (i_op == DMBA_OP_FULL);
			do_write <= i_write && (i_op == DMBA_OP_BANKED);
			full_move <= (i_op == DMBA_OP_FULL);
			load_bank <= (i_op == DMBA_OP_LOAD_BANK);
			lit_q <= i_literal;
		end
	end

	// ----------------------------------------
	// bank select register
	// ----------------------------------------
	// next bank value, shared by register and output copy
	always_comb begin
		next_bank_select = bank_select;
		if (phase == DMBA_Q4) begin
			if (load_bank) begin
				next_bank_select = lit_q[3:0];
			end else if (do_write && !full_move && wr_addr == DMBA_BANK_SEL_ADDR) begin
				next_bank_select = wr_data[3:0];
			end else if (full_move && wr_addr == DMBA_BANK_SEL_ADDR) begin
				next_bank_select = o_rd_data[3:0];
			end
		end
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			bank_select <= DMBA_BANK_RESET;
		end else begin
			bank_select <= next_bank_select;
		end
	end

	assign sfr_hit = (rd_addr == DMBA_BANK_SEL_ADDR);
	assign sfr_rd = {4'h0, bank_select};

	// ----------------------------------------
	// array access
	// ----------------------------------------
	// read in q2, write in q4
	assign mif.rd_en = (phase == DMBA_Q2) && do_read;
	assign mif.rd_addr = rd_addr;
	assign mif.wr_en = (phase == DMBA_Q4) && (do_write || full_move)
		&& wr_addr != DMBA_BANK_SEL_ADDR;
	assign mif.wr_addr = wr_addr;
	assign mif.wr_data = full_move ? o_rd_data : wr_data;

	dmba_ram u_ram (
		.i_clk(i_clk),
		.mem(mif)
	);

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			rd_pending <= 1'b0;
		end else begin
			rd_pending <= mif.rd_en;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	// zero from array for absent
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			o_rd_data <= 8'h00;
			o_rd_valid <= 1'b0;
		end else begin
			o_rd_valid <= rd_pending;
			if (rd_pending) begin
				o_rd_data <= sfr_hit ? sfr_rd : mif.rd_data;
			end
		end
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			o_addr <= 12'h000;
			o_wr_done <= 1'b0;
			o_busy <= 1'b0;
			o_bank_select <= 8'h00;
		end else begin
			if (phase == DMBA_Q1 && i_start) begin
				o_addr <= next_addr;
			end
			o_wr_done <= (phase == DMBA_Q4) && (do_write || full_move || load_bank);
			o_busy <= (phase == DMBA_Q1) ? i_start : (phase != DMBA_Q4);
			o_bank_select <= {4'h0, next_bank_select};
		end
	end
endmodule : dmba_top

// [dmba_top_test.sv]
// self-checking bench for bank addressing
`timescale 1ns/1ps
module dmba_top_test;
	import dmba_pkg::*;
	logic i_clk = 0, i_reset = 1, i_start, i_access_bit, i_write, i_ext_set_enable = 0;
	dmba_op_t i_op;
	logic [7:0] i_offset, i_literal, i_wr_data, o_rd_data, o_bank_select, rd;
	logic done;
	logic [11:0] dst = 12'h7ab;
	logic [11:0] i_src_addr, i_dst_addr, o_addr;
	logic o_rd_valid, o_wr_done, o_busy;
	int errors = 0, num_checks = 0, cycles = 0;
	always #50 i_clk = ~i_clk;
	dmba_top i_dmba_top (.*);
	dmba_core_model i_dmba_core_model (.i_clk(i_clk), .i_busy(o_busy), .i_rd_valid(o_rd_valid),
		.i_rd_data(o_rd_data), .o_start(i_start), .o_op(i_op), .o_access_bit(i_access_bit),
		.i_wr_done(o_wr_done),
		.o_offset(i_offset), .o_src_addr(i_src_addr), .o_dst_addr(i_dst_addr),
		.o_literal(i_literal), .o_write(i_write), .o_wr_data(i_wr_data));
	task summarize;
		$display("checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : summarize
	always @(posedge i_clk) begin
		cycles++;
		if (cycles == 3000) begin
			errors++;
			summarize();
		end
	end
	task chk12(input logic [11:0] g, input logic [11:0] e);
		num_checks++;
		if (g !== e) begin
			errors++;
			$display("BAD %0t addr %h want %h", $time, g, e);
		end
	endtask : chk12
	task chk8(input logic [7:0] g, input logic [7:0] e);
		num_checks++;
		if (g !== e) begin
			errors++;
			$display("BAD %0t byte %h want %h", $time, g, e);
		end
	endtask : chk8
	task chk1(input logic g, input logic e);
		num_checks++;
		if (g !== e) begin
			errors++;
			$display("BAD %0t flag %b want %b", $time, g, e);
		end
	endtask : chk1
	task go(input dmba_op_t op, input logic a, input logic [7:0] off, input logic [11:0] s,
		input logic wr, input logic [7:0] wd);
		logic ok;
		i_dmba_core_model.issue(op, a, off, s, dst, wr, wd, rd, done, ok);
		if (ok !== 1'b1) begin
			errors++;
			$display("BAD %0t no response from block", $time);
		end
	endtask : go
	task t_reset;
		i_reset = 1;
		repeat (16) @(negedge i_clk);
		i_reset = 0;
		chk8(o_bank_select, 8'h00);
		$display("reset test done");
	endtask : t_reset
	task t_bank;
		go(DMBA_OP_LOAD_BANK, 0, 8'ha5, 0, 0, 0);
		chk8(o_bank_select, 8'h05);
		chk1(done, 1'b1);
		go(DMBA_OP_BANKED, 1, 8'h33, 0, 1, 8'h5a);
		chk12(o_addr, 12'h533);
		chk1(done, 1'b1);
		go(DMBA_OP_BANKED, 0, 8'he0, 0, 0, 0);
		chk8(rd, 8'h05);
		$display("bank test done");
	endtask : t_bank
	task t_access;
		go(DMBA_OP_BANKED, 0, 8'h10, 0, 1, 8'h77);
		chk12(o_addr, 12'h010);
		go(DMBA_OP_BANKED, 0, 8'h80, 0, 0, 0);
		chk12(o_addr, 12'hf80);
		chk1(done, 1'b0);
		go(DMBA_OP_LOAD_BANK, 0, 8'hf0, 0, 0, 0);
		go(DMBA_OP_BANKED, 1, 8'h10, 0, 0, 0);
		chk8(rd, 8'h77);
		$display("access test done");
	endtask : t_access
	task t_full;
		go(DMBA_OP_FULL, 1, 8'h00, 12'h533, 1, 8'h00);
		chk12(o_addr, 12'h533);
		chk1(done, 1'b1);
		go(DMBA_OP_LOAD_BANK, 0, 8'h07, 0, 0, 0);
		go(DMBA_OP_BANKED, 1, 8'hab, 0, 0, 0);
		chk8(rd, 8'h5a);
		$display("full test done");
	endtask : t_full
	task t_sfr;
		go(DMBA_OP_BANKED, 0, 8'he0, 0, 1, 8'h3c);
		chk8(o_bank_select, 8'h0c);
		go(DMBA_OP_BANKED, 0, 8'he0, 0, 0, 0);
		chk8(rd, 8'h0c);
		dst = 12'hfe0;
		go(DMBA_OP_FULL, 0, 8'h00, 12'h010, 0, 0);
		dst = 12'h7ab;
		chk8(rd, 8'h77);
		chk8(o_bank_select, 8'h07);
		$display("sfr test done");
	endtask : t_sfr
	task t_retain;
		t_reset();
		go(DMBA_OP_FULL, 0, 8'h00, 12'h533, 0, 0);
		chk8(rd, 8'h5a);
		$display("retain test done");
	endtask : t_retain
	initial begin
		t_reset();
		t_bank();
		t_access();
		t_full();
		t_sfr();
		t_retain();
		summarize();
	end
endmodule : dmba_top_test
